// file: src/ev_cond_if.sv
// Conditioned event edges passed from the input stage to the timer core
`timescale 1ns/100ps
`default_nettype none
interface ev_cond_if;
	logic filter_en;
	logic rise;
	logic fall;
	modport src (input filter_en, output rise, output fall);
	modport snk (output filter_en, input rise, input fall);
endinterface : ev_cond_if
`default_nettype wire

// file: src/ev_conditioner.sv
// Event input stage: optional noise cancellation and edge detection
`timescale 1ns/100ps
`default_nettype none
`include "evt_timer_defs.svh"
module ev_conditioner #(
	parameter int FILTER_LEN = `FILTER_LEN_DEF
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic event_in,
	ev_cond_if.src    cond
);
	localparam int CW = $clog2(FILTER_LEN + 1);

	logic          level_q;
	logic [CW-1:0] stable_q;
	logic          rise_q;
	logic          fall_q;
	logic          level_d;

	// A change must persist for FILTER_LEN samples before it counts as an edge
	always_comb
	begin
		level_d = level_q;
		if (!cond.filter_en)
			level_d = event_in;
		else if (event_in != level_q && stable_q == CW'(FILTER_LEN - 1))
			level_d = event_in;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stable_q <= '0;
		else if (event_in == level_q || !cond.filter_en)
			stable_q <= '0;
		else if (stable_q != CW'(FILTER_LEN - 1))
			stable_q <= stable_q + CW'(1);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			level_q <= 1'b0;
			rise_q  <= 1'b0;
			fall_q  <= 1'b0;
		end
		else
		begin
			level_q <= level_d;
			rise_q  <= level_d & ~level_q;
			fall_q  <= ~level_d & level_q;
		end
	end

	assign cond.rise = rise_q;
	assign cond.fall = fall_q;

	a_filter_delay: assert property (@(posedge pclk) disable iff (!presetn)
		cond.filter_en && rise_q |-> $past(event_in, FILTER_LEN))
		else $error("filtered rise without a held input");
endmodule : ev_conditioner
`default_nettype wire

// file: src/event_timer_mode_control.sv
// Event timer: mode decoding, event actions, interrupt and APB registers
`timescale 1ns/100ps
`default_nettype none
`include "evt_timer_defs.svh"
module event_timer_mode_control
	import evt_timer_pkg::*;
#(
	parameter int CNT_W      = 16,
	parameter int FILTER_LEN = `FILTER_LEN_DEF
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        event_in,
	output logic             irq
);
	counter_mode_t    mode_q;
	logic [7:0]       event_control_q;
	logic             irq_enable_q;
	logic             flag_q;
	logic             run_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] snap_q;
	pw_stage_t        stage_q;
	logic [31:0]      prdata_q;
	logic             pready_q;
	logic             pslverr_q;
	logic             irq_q;

	ev_cond_if cond ();

	ev_conditioner #(
		.FILTER_LEN (FILTER_LEN)
	) u_cond (
		.pclk     (pclk),
		.presetn  (presetn),
		.event_in (event_in),
		.cond     (cond)
	);

	assign cond.filter_en = event_control_q[`EVC_FILTER_BIT];

	// APB: the access phase always takes one wait state, pready is a flop
	logic       access;
	logic       wr_done;
	logic       rd_done;
	logic [7:0] index;
	logic       mapped;

	assign access  = psel & penable & ~pready_q;
	assign wr_done = psel & penable & pready_q & pwrite;
	assign rd_done = psel & penable & pready_q & ~pwrite;
	assign index   = {2'b00, paddr[7:2]};

	always_comb
	begin
		case (index)
			`IDX_MODE_CTRL, `IDX_EVENT_CONTROL, `IDX_IRQ_ENABLE, `IDX_IRQ_FLAGS,
			`IDX_STATUS, `IDX_COUNT, `IDX_SNAPSHOT:
				mapped = (paddr[1:0] == 2'b00);
			default:
				mapped = 1'b0;
		endcase
	end

	logic [31:0] rd_val;

	always_comb
	begin
		rd_val = 32'h0000_0000;
		case (index)
			`IDX_MODE_CTRL:     rd_val[`MODE_FIELD_MSB:0] = mode_q;
			`IDX_EVENT_CONTROL: rd_val[`BYTE_MSB:0] = event_control_q;
			`IDX_IRQ_ENABLE:    rd_val[`IRQ_SNAPSHOT_BIT] = irq_enable_q;
			`IDX_IRQ_FLAGS:     rd_val[`IRQ_SNAPSHOT_BIT] = flag_q;
			`IDX_STATUS:        rd_val[`STATUS_RUN_BIT] = run_q;
			`IDX_COUNT:         rd_val[CNT_W-1:0] = cnt_q;
			`IDX_SNAPSHOT:      rd_val[CNT_W-1:0] = snap_q;
			default:            rd_val = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end
		else
		begin
			pready_q  <= access;
			pslverr_q <= access & ~mapped;
			if (access && !pwrite)
				prdata_q <= rd_val;
		end
	end

	logic wr_mode;
	logic wr_evc;
	logic wr_ien;
	logic wr_flags;
	logic wr_cnt;
	logic wr_snap;
	logic rd_snap;

	assign wr_mode  = wr_done && index == `IDX_MODE_CTRL && paddr[1:0] == 2'b00;
	assign wr_evc   = wr_done && index == `IDX_EVENT_CONTROL && paddr[1:0] == 2'b00;
	assign wr_ien   = wr_done && index == `IDX_IRQ_ENABLE && paddr[1:0] == 2'b00;
	assign wr_flags = wr_done && index == `IDX_IRQ_FLAGS && paddr[1:0] == 2'b00;
	assign wr_cnt   = wr_done && index == `IDX_COUNT && paddr[1:0] == 2'b00;
	assign wr_snap  = wr_done && index == `IDX_SNAPSHOT && paddr[1:0] == 2'b00;
	assign rd_snap  = rd_done && index == `IDX_SNAPSHOT && paddr[1:0] == 2'b00;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mode_q <= MODE_PERIODIC;
		else if (wr_mode)
			mode_q <= counter_mode_t'(pwdata[`MODE_FIELD_MSB:0]);
	end

	localparam logic [7:0] EVC_MASK = (8'h01 << `EVC_INPUT_EN_BIT)
		| (8'h01 << `EVC_EDGE_BIT) | (8'h01 << `EVC_FILTER_BIT);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			event_control_q <= `REG_RESET_8;
			irq_enable_q    <= 1'b0;
		end
		else
		begin
			if (wr_evc)
				event_control_q <= pwdata[`BYTE_MSB:0] & EVC_MASK;
			if (wr_ien)
				irq_enable_q <= pwdata[`IRQ_SNAPSHOT_BIT];
		end
	end

	// Event qualification: input enable gates both edges, edge bit picks the acting one except in one-shot mode, where set lets both edges start
	logic edge_sel;
	logic act_rise;
	logic act_fall;
	logic sel_edge;
	logic oth_edge;

	assign edge_sel = event_control_q[`EVC_EDGE_BIT];
	assign act_rise = event_control_q[`EVC_INPUT_EN_BIT] & cond.rise;
	assign act_fall = event_control_q[`EVC_INPUT_EN_BIT] & cond.fall;
	assign sel_edge = edge_sel ? act_fall : act_rise;
	assign oth_edge = edge_sel ? act_rise : act_fall;

	logic do_start;
	logic do_stop;
	logic do_restart;
	logic do_snap;
	logic do_flag;
	logic event_snapshot_irq_mode;
	logic at_top;

	assign event_snapshot_irq_mode = mode_q == MODE_CAPTURE || mode_q == MODE_PERIOD
		|| mode_q == MODE_WIDTH || mode_q == MODE_PER_WIDTH;
	assign at_top    = run_q && cnt_q == snap_q;

	always_comb
	begin
		do_start   = 1'b0;
		do_stop    = 1'b0;
		do_restart = 1'b0;
		do_snap    = 1'b0;
		do_flag    = 1'b0;
		case (mode_q)
			MODE_TIMEOUT:
			begin
				do_start = sel_edge;
				do_stop  = oth_edge;
				do_flag  = at_top;
			end
			MODE_CAPTURE:
			begin
				do_snap = sel_edge;
				do_flag = sel_edge;
			end
			MODE_PERIOD:
			begin
				do_snap    = sel_edge;
				do_restart = sel_edge;
				do_flag    = sel_edge;
			end
			MODE_WIDTH:
			begin
				do_restart = sel_edge;
				do_snap    = oth_edge;
				do_flag    = oth_edge;
			end
			MODE_PER_WIDTH:
			begin
				do_restart = stage_q == PW_IDLE && sel_edge;
				do_start   = do_restart;
				do_snap    = stage_q == PW_ARMED && oth_edge;
				do_stop    = stage_q == PW_CAPTURED && sel_edge;
				do_flag    = do_stop;
			end
			MODE_ONE_SHOT:
			begin
				do_start = edge_sel ? (act_rise | act_fall) : act_rise;
				do_stop  = at_top;
				do_flag  = at_top;
			end
			MODE_PERIODIC:
				do_flag = at_top;
			MODE_BYTE_PWM:
				do_flag = run_q && cnt_q[`BYTE_MSB:0] == snap_q[`BYTE_MSB:0];
			default:
				do_flag = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stage_q <= PW_IDLE;
		else if (mode_q != MODE_PER_WIDTH || wr_mode)
			stage_q <= PW_IDLE;
		else
		begin
			case (stage_q)
				PW_IDLE:     if (do_restart) stage_q <= PW_ARMED;
				PW_ARMED:    if (do_snap) stage_q <= PW_CAPTURED;
				PW_CAPTURED: if (do_stop) stage_q <= PW_IDLE;
				default:     stage_q <= PW_IDLE;
			endcase
		end
	end

	// Modes that wait for an event stop the counter when entered
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			run_q <= 1'b1;
		else if (wr_mode)
			run_q <= !(pwdata[`MODE_FIELD_MSB:0] == MODE_TIMEOUT
				|| pwdata[`MODE_FIELD_MSB:0] == MODE_ONE_SHOT
				|| pwdata[`MODE_FIELD_MSB:0] == MODE_PER_WIDTH);
		else if (do_stop)
			run_q <= 1'b0;
		else if (do_start)
			run_q <= 1'b1;
	end

	// Software write has priority over counting
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_q <= `REG_RESET_16;
		else if (wr_cnt)
			cnt_q <= pwdata[CNT_W-1:0];
		else if (do_restart || (at_top && !event_snapshot_irq_mode && mode_q != MODE_BYTE_PWM))
			cnt_q <= '0;
		else if (run_q)
			cnt_q <= cnt_q + CNT_W'(1);
	end

	// The snapshot register doubles as the top value in the counting modes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			snap_q <= `REG_RESET_16;
		else if (do_snap)
			snap_q <= cnt_q;
		else if (wr_snap)
			snap_q <= pwdata[CNT_W-1:0];
	end

	// A new event in the clearing cycle keeps the flag set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flag_q <= 1'b0;
		else if (do_flag)
			flag_q <= 1'b1;
		else if ((wr_flags && pwdata[`IRQ_SNAPSHOT_BIT]) || (rd_snap && event_snapshot_irq_mode))
			flag_q <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_q <= 1'b0;
		else
			irq_q <= flag_q & irq_enable_q;
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign irq     = irq_q;

	default clocking dflt @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_ignore_events: assert property ((mode_q == MODE_PERIODIC || mode_q == MODE_BYTE_PWM)
		&& !wr_snap |=> $stable(snap_q))
		else $error("snapshot changed in an event-free mode");
	a_capture_edge: assert property (mode_q == MODE_CAPTURE && sel_edge && !wr_mode
		|=> snap_q == $past(cnt_q) && flag_q)
		else $error("capture edge did not snapshot and flag");
	a_period_restart: assert property (mode_q == MODE_PERIOD && sel_edge && !wr_cnt
		|=> cnt_q == '0 && flag_q)
		else $error("period edge did not restart counter");
	a_width_snap: assert property (mode_q == MODE_WIDTH && oth_edge && !wr_mode
		|=> snap_q == $past(cnt_q))
		else $error("width end edge did not snapshot");
	a_timeout_start: assert property (mode_q == MODE_TIMEOUT && sel_edge && !oth_edge
		&& !wr_mode |=> run_q)
		else $error("time-out start edge did not start counter");
	a_input_gated: assert property (!event_control_q[`EVC_INPUT_EN_BIT]
		|-> !sel_edge && !oth_edge)
		else $error("event acted while input disabled");
	a_irq_follows: assert property (flag_q && irq_enable_q |=> irq)
		else $error("interrupt missing with flag and enable set");
	a_irq_needs_en: assert property (!irq_enable_q ##1 !irq_enable_q |-> !irq)
		else $error("interrupt raised while disabled");
	a_w1c_zero: assert property (wr_flags && !pwdata[`IRQ_SNAPSHOT_BIT] && flag_q
		|=> flag_q)
		else $error("writing zero cleared the flag");
	a_unused_zero: assert property (access && !pwrite && index == `IDX_EVENT_CONTROL
		|=> (prdata & ~{24'h00_0000, EVC_MASK}) == 32'h0000_0000)
		else $error("unused event control bits read nonzero");
	a_pw_sequence: assert property (mode_q == MODE_PER_WIDTH && stage_q == PW_CAPTURED
		&& sel_edge && !wr_mode |=> !run_q && flag_q)
		else $error("period-width second edge did not stop");
	a_apb_wait: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
		else $error("slave answer timing off");

	c_capture: cover property (mode_q == MODE_CAPTURE && sel_edge);
	c_pw_done: cover property (mode_q == MODE_PER_WIDTH && stage_q == PW_CAPTURED && sel_edge);
	c_irq_up: cover property (!irq ##1 irq);
	c_set_clear: cover property (do_flag && wr_flags && pwdata[`IRQ_SNAPSHOT_BIT]);
endmodule : event_timer_mode_control
`default_nettype wire

// file: src/evt_timer_defs.svh
// Register map, field positions and reset values of the event timer
`ifndef EVT_TIMER_DEFS_SVH
`define EVT_TIMER_DEFS_SVH

`define IDX_MODE_CTRL     8'h01
`define IDX_EVENT_CONTROL 8'h04
`define IDX_IRQ_ENABLE    8'h05
`define IDX_IRQ_FLAGS     8'h06
`define IDX_STATUS        8'h07
`define IDX_COUNT         8'h0A
`define IDX_SNAPSHOT      8'h0C

`define MODE_FIELD_MSB    2
`define EVC_INPUT_EN_BIT  0
`define EVC_EDGE_BIT      4
`define EVC_FILTER_BIT    6
`define IRQ_SNAPSHOT_BIT  0
`define STATUS_RUN_BIT    0
`define BYTE_MSB          7

`define REG_RESET_8       8'h00
`define REG_RESET_16      16'h0000
`define FILTER_LEN_DEF    4

`endif

// file: src/evt_timer_pkg.sv
// Types shared by the event timer modules
package evt_timer_pkg;

	typedef enum logic [2:0] {
		MODE_PERIODIC  = 3'h0,
		MODE_TIMEOUT   = 3'h1,
		MODE_CAPTURE   = 3'h2,
		MODE_PERIOD    = 3'h3,
		MODE_WIDTH     = 3'h4,
		MODE_PER_WIDTH = 3'h5,
		MODE_ONE_SHOT  = 3'h6,
		MODE_BYTE_PWM  = 3'h7
	} counter_mode_t;

	typedef enum logic [2:0] {
		PW_IDLE     = 3'h1,
		PW_ARMED    = 3'h2,
		PW_CAPTURED = 3'h4
	} pw_stage_t;

endpackage : evt_timer_pkg

// file: verification/event_source.sv
// Event source model: drives the timer's event input in whole clock cycles
`timescale 1ns/100ps
`default_nettype none
module event_source (
	input  wire logic pclk,
	output var  logic ev
);
	initial ev = 1'b0;

	// A level always lasts whole cycles, so a glitch is only made on purpose
	task automatic hold(input logic lvl, input int n);
		ev <= lvl;
		repeat (n) @(posedge pclk);
	endtask : hold
endmodule : event_source
`default_nettype wire

// file: verification/event_timer_mode_control_bench.sv
// Self-checking bench of the event timer: APB tasks, event pulses, read checks
`timescale 1ns/100ps
`default_nettype none
`define CMP(nm, e, g) \
	begin n_tests++; if ((g) !== (e)) begin miscompares++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module event_timer_mode_control_bench
	import evt_timer_pkg::*;
;
	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        event_in;
	logic        irq;
	logic [7:0]  lfsr_q  = 8'h27;
	logic [32:0] exp_q[$];
	logic [32:0] exp_v;
	int          miscompares = 0;
	int          n_tests     = 0;

	always #50 pclk = ~pclk;

	event_timer_mode_control #(.CNT_W(16), .FILTER_LEN(4)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .event_in(event_in), .irq(irq)
	);

	event_source es (.pclk(pclk), .ev(event_in));

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			miscompares++;
			report_and_stop();
		end
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	// Expected answer is queued first; the monitor below checks it
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic er = 1'b0);
		exp_q.push_back({er, d});
		apb(1'b0, a, 32'h0);
	endtask : rd

	task automatic setm(input counter_mode_t m);
		wr(8'h04, {29'h0, m});
	endtask : setm

	task automatic ev(input logic lvl, input int n);
		es.hold(lvl, n);
	endtask : ev

	// irq follows the flag one cycle late, so let two edges pass first
	task automatic chk_irq(input logic e);
		repeat (2) @(posedge pclk);
		`CMP("irq", e, irq)
	endtask : chk_irq

	always @(posedge pclk)
		if (psel && penable && pready === 1'b1 && !pwrite)
		begin
			if (exp_q.size() == 0)
				`CMP("unexpected read", 33'h0, {pslverr, prdata})
			else
			begin
				exp_v = exp_q.pop_front();
				`CMP($sformatf("read %0h", paddr), exp_v, {pslverr, prdata})
			end
		end

	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(8'h10, 32'h0);
		rd(8'h14, 32'h0);
		rd(8'h18, 32'h1);
		repeat (4)
		begin
			lfsr_q = lfsr(lfsr_q);
			wr(8'h10, {lfsr_q, 16'h0, lfsr_q});
			rd(8'h10, {24'h0, lfsr_q & 8'h51});
			wr(8'h14, {24'h0, lfsr_q});
			rd(8'h14, {31'h0, lfsr_q[0]});
		end
		rd(8'h08, 32'h0, 1'b1);
		for (int i = 0; i < 8; i++)
		begin
			wr(8'h04, 32'(i));
			rd(8'h04, 32'(i));
		end
		setm(MODE_WIDTH);
		wr(8'h10, 32'h01);
		wr(8'h14, 32'h01);
		wr(8'h18, 32'h01);
		chk_irq(1'b0);
		ev(1'b1, 7);
		ev(1'b0, 5);
		chk_irq(1'b1);
		wr(8'h14, 32'h00);
		chk_irq(1'b0);
		wr(8'h14, 32'h01);
		chk_irq(1'b1);
		rd(8'h30, 32'h6);
		rd(8'h18, 32'h0);
		chk_irq(1'b0);
		wr(8'h10, 32'h11);
		ev(1'b1, 3);
		ev(1'b0, 9);
		ev(1'b1, 4);
		rd(8'h30, 32'h8);
		rd(8'h18, 32'h0);
		ev(1'b0, 2);
		setm(MODE_PERIOD);
		wr(8'h10, 32'h01);
		ev(1'b1, 4);
		ev(1'b0, 6);
		ev(1'b1, 4);
		ev(1'b0, 2);
		rd(8'h30, 32'h9);
		rd(8'h18, 32'h0);
		ev(1'b1, 4);
		ev(1'b0, 2);
		wr(8'h18, 32'h0);
		rd(8'h18, 32'h1);
		wr(8'h18, 32'h1);
		rd(8'h18, 32'h0);
		setm(MODE_CAPTURE);
		wr(8'h10, 32'h11);
		ev(1'b1, 6);
		rd(8'h18, 32'h0);
		ev(1'b0, 6);
		rd(8'h18, 32'h1);
		wr(8'h18, 32'h1);
		wr(8'h10, 32'h10);
		ev(1'b1, 4);
		ev(1'b0, 6);
		rd(8'h18, 32'h0);
		wr(8'h10, 32'h41);
		ev(1'b1, 2);
		ev(1'b0, 8);
		rd(8'h18, 32'h0);
		ev(1'b1, 8);
		rd(8'h18, 32'h1);
		ev(1'b0, 8);
		wr(8'h18, 32'h1);
		wr(8'h30, 32'hFFFF);
		for (int k = 0; k < 2; k++)
		begin
			wr(8'h28, 32'h0);
			wr(8'h04, k == 0 ? 32'h0 : 32'h7);
			wr(8'h10, 32'h01);
			wr(8'h18, 32'h1);
			ev(1'b1, 4);
			ev(1'b0, 4);
			rd(8'h18, 32'h0);
			rd(8'h30, 32'hFFFF);
		end
		for (int e = 0; e < 2; e++)
		begin
			wr(8'h10, e == 1 ? 32'h11 : 32'h01);
			setm(MODE_TIMEOUT);
			ev(1'b1, 4);
			rd(8'h1C, 32'(e == 0));
			ev(1'b0, 4);
			rd(8'h1C, 32'(e));
		end
		for (int e = 0; e < 2; e++)
		begin
			wr(8'h10, e == 1 ? 32'h11 : 32'h01);
			ev(1'b1, 4);
			wr(8'h28, 32'h0);
			setm(MODE_ONE_SHOT);
			ev(1'b0, 4);
			rd(8'h1C, 32'(e));
			ev(1'b1, 4);
			rd(8'h1C, 32'h1);
			ev(1'b0, 2);
		end
		wr(8'h10, 32'h01);
		setm(MODE_PER_WIDTH);
		ev(1'b1, 5);
		ev(1'b0, 7);
		ev(1'b1, 3);
		rd(8'h1C, 32'h0);
		rd(8'h18, 32'h1);
		rd(8'h30, 32'h4);
		rd(8'h18, 32'h0);
		repeat (2) @(posedge pclk);
		`CMP("pending reads", 0, exp_q.size())
		report_and_stop();
	end
endmodule : event_timer_mode_control_bench
`default_nettype wire
